// ### logic/host_port_pkg.sv
// Constants and types shared by the host port pin logic
package host_port_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 16;
  localparam int unsigned WORD_W    = 24;
  localparam int unsigned VEC_W     = 7;

  // ---------------------------------------------------------------
  // Port control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_HOST_EN_BIT = 0;
  localparam int unsigned CTRL_MUX_BIT     = 1;
  localparam int unsigned CTRL_AS_POL_BIT  = 2;
  localparam int unsigned CTRL_CS_POL_BIT  = 3;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;

  // ---------------------------------------------------------------
  // Pin positions in host mode
  // ---------------------------------------------------------------
  localparam int unsigned PIN_ADDR0 = 8;
  localparam int unsigned PIN_ADDR1 = 9;
  localparam int unsigned PIN_ADDR2 = 10;
  localparam int unsigned PIN_RD    = 11;
  localparam int unsigned PIN_WR    = 12;
  localparam int unsigned PIN_CS    = 13;

  // ---------------------------------------------------------------
  // Host side byte addresses
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_CMD    = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_HIGH   = 3'h5;
  localparam logic [2:0] ADDR_MIDDLE = 3'h6;
  localparam logic [2:0] ADDR_LOW    = 3'h7;

  typedef enum logic [1:0] {MODE_GPIO, MODE_NONMUX, MODE_MUX} port_mode_e;

endpackage : host_port_pkg

// ### logic/pin_sync_if.sv
// Raw and synchronised pin levels between the port logic and its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int unsigned W = 16);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : pin_sync_if
`default_nettype wire

// ### logic/pin_sync.sv
// Two-flop synchroniser for the asynchronous host pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 16
)(
  input  wire logic  clk_sys,
  input  wire logic  reset,
  pin_sync_if.sync   pins
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Idle-high reset, so no false strobe edge after reset
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else begin
      stage1_reg <= pins.raw;
      stage2_reg <= stage1_reg;
    end
  end

  assign pins.synced = stage2_reg;
endmodule : pin_sync
`default_nettype wire

// ### logic/host_port_pin_config.sv
// Host port pin function select, host byte registers and handshake flags
//
// How it works
// - Host transmit bytes move to core word
// - Port control register selects every pin function
// - Non-multiplexed host: pins 0-7 bidirectional data
// - Multiplexed host: pins 0-7 shared address/data
// - GPIO: direction register sets each pin
// - Non-multiplexed: three address pins give lines 0-2
// - Multiplexed: pins 9, 10 and 13 give address lines 8-10
// - Multiplexed: address strobe, polarity programmable, low default
// - Non-multiplexed: chip select, polarity programmable, low default
// - Input pins ignored while reset asserted
// - Stop: inputs ignored, outputs tri-stated
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_config #(
  parameter int unsigned PIN_COUNT = host_port_pkg::PIN_COUNT,
  parameter int unsigned WORD_W    = host_port_pkg::WORD_W
)(
  input  wire logic [15:0]                        port_ctrl,
  input  wire logic                               clk_sys,
  input  wire logic                               reset,
  input  wire logic                               stop_mode,
  input  wire logic [PIN_COUNT-1:0]               gpio_dir,
  input  wire logic [PIN_COUNT-1:0]               gpio_out,
  input  wire logic [PIN_COUNT-1:0]               pb_in,
  output logic      [PIN_COUNT-1:0]               pb_out,
  output logic      [PIN_COUNT-1:0]               pb_oe,
  output logic      [PIN_COUNT-1:0]               gpio_in_val,
  input  wire logic [WORD_W-1:0]                  core_tx_word,
  input  wire logic                               core_tx_load,
  input  wire logic                               core_rx_ack,
  input  wire logic                               core_cmd_ack,
  output logic      [WORD_W-1:0]                  core_side_receive_word,
  output logic                                    core_rx_valid,
  output logic                                    receive_full_flag,
  output logic                                    transmit_empty_flag,
  output logic      [host_port_pkg::VEC_W-1:0]    host_vector_value,
  output logic                                    host_command_bit
);

  // ---------------------------------------------------------------
  // Synchronised pins and strobe edges
  // ---------------------------------------------------------------
  pin_sync_if #(.W(PIN_COUNT)) sif ();
  assign sif.raw = pb_in;
  pin_sync #(.W(PIN_COUNT)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pins    (sif)
  );
  logic [PIN_COUNT-1:0]      pins_s;
  logic [PIN_COUNT-1:0]      pins_d_reg;
  logic [15:0]               ctrl_reg;
  logic [10:0]               addr_reg;
  logic [7:0]                transmit_byte_high_reg;
  logic [7:0]                transmit_byte_middle_reg;
  logic [7:0]                receive_byte_high_reg;
  logic [7:0]                receive_byte_middle_reg;
  logic [7:0]                receive_byte_low_reg;
  host_port_pkg::port_mode_e mode;
  logic                      host_live;
  logic                      cs_act;
  logic                      as_act;
  logic                      sel;
  logic                      rd_act;
  logic                      rd_start;
  logic                      wr_end;
  logic                      wr_go;
  logic                      rd_go;
  assign pins_s = sif.synced;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pins_d_reg <= '1;
    end else begin
      pins_d_reg <= pins_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_reg <= host_port_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= port_ctrl;
    end
  end

  always_comb begin
    if (!ctrl_reg[host_port_pkg::CTRL_HOST_EN_BIT]) begin
      mode = host_port_pkg::MODE_GPIO;
    end else if (ctrl_reg[host_port_pkg::CTRL_MUX_BIT]) begin
      mode = host_port_pkg::MODE_MUX;
    end else begin
      mode = host_port_pkg::MODE_NONMUX;
    end
  end
  // Polarity bit set means active high; reset value gives active low
  assign cs_act = (pins_s[host_port_pkg::PIN_CS]
                   == ctrl_reg[host_port_pkg::CTRL_CS_POL_BIT]);
  assign as_act = (pins_s[host_port_pkg::PIN_ADDR0]
                   == ctrl_reg[host_port_pkg::CTRL_AS_POL_BIT]);
  assign host_live = (mode != host_port_pkg::MODE_GPIO) && !stop_mode;
  assign sel       = (mode == host_port_pkg::MODE_MUX) ? 1'b1 : cs_act;
  assign rd_act    = !pins_s[host_port_pkg::PIN_RD];
  assign rd_start  = !pins_s[host_port_pkg::PIN_RD] && pins_d_reg[host_port_pkg::PIN_RD];
  assign wr_end    = pins_s[host_port_pkg::PIN_WR] && !pins_d_reg[host_port_pkg::PIN_WR];
  assign wr_go     = host_live && sel && wr_end;
  assign rd_go     = host_live && sel && rd_start;

  // ---------------------------------------------------------------
  // Host address capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_reg <= '0;
    end else if (host_live && mode == host_port_pkg::MODE_NONMUX) begin
      addr_reg <= {8'h00, pins_s[host_port_pkg::PIN_ADDR2],
                   pins_s[host_port_pkg::PIN_ADDR1], pins_s[host_port_pkg::PIN_ADDR0]};
    end else if (host_live && mode == host_port_pkg::MODE_MUX && as_act) begin
      addr_reg <= {pins_s[host_port_pkg::PIN_CS], pins_s[host_port_pkg::PIN_ADDR2],
                   pins_s[host_port_pkg::PIN_ADDR1], pins_s[7:0]};
    end
  end

  function automatic logic [7:0] read_byte(input logic [2:0] a);
    case (a)
      host_port_pkg::ADDR_STATUS: read_byte = {6'h00, transmit_empty_flag, receive_full_flag};
      host_port_pkg::ADDR_HIGH:   read_byte = receive_byte_high_reg;
      host_port_pkg::ADDR_MIDDLE: read_byte = receive_byte_middle_reg;
      host_port_pkg::ADDR_LOW:    read_byte = receive_byte_low_reg;
      host_port_pkg::ADDR_CMD:    read_byte = {host_command_bit, host_vector_value};
      default:                    read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // ---------------------------------------------------------------
  // Host to core path
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      transmit_byte_high_reg   <= '0;
      transmit_byte_middle_reg <= '0;
      core_side_receive_word   <= '0;
      core_rx_valid            <= 1'b0;
      transmit_empty_flag      <= 1'b1;
    end else begin
      if (core_rx_ack) begin
        core_rx_valid       <= 1'b0;
        transmit_empty_flag <= 1'b1;
      end
      if (wr_go && addr_reg[2:0] == host_port_pkg::ADDR_HIGH) begin
        transmit_byte_high_reg <= pins_s[7:0];
      end
      if (wr_go && addr_reg[2:0] == host_port_pkg::ADDR_MIDDLE) begin
        transmit_byte_middle_reg <= pins_s[7:0];
      end
      // Low byte completes the word; a write wins over a same-cycle ack
      if (wr_go && addr_reg[2:0] == host_port_pkg::ADDR_LOW) begin
        core_side_receive_word <= WORD_W'({transmit_byte_high_reg,
                                           transmit_byte_middle_reg, pins_s[7:0]});
        core_rx_valid          <= 1'b1;
        transmit_empty_flag    <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      host_vector_value <= '0;
      host_command_bit  <= 1'b0;
    end else begin
      if (core_cmd_ack) begin
        host_command_bit <= 1'b0;
      end
      if (wr_go && addr_reg[2:0] == host_port_pkg::ADDR_CMD) begin
        host_vector_value <= pins_s[host_port_pkg::VEC_W-1:0];
        if (pins_s[7]) begin
          host_command_bit <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Core to host path
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      receive_byte_high_reg   <= '0;
      receive_byte_middle_reg <= '0;
      receive_byte_low_reg    <= '0;
      receive_full_flag       <= 1'b0;
    end else begin
      if (rd_go && addr_reg[2:0] == host_port_pkg::ADDR_LOW) begin
        receive_full_flag <= 1'b0;
      end
      if (core_tx_load) begin
        {receive_byte_high_reg, receive_byte_middle_reg, receive_byte_low_reg} <=
          core_tx_word[23:0];
        receive_full_flag <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive and GPIO input
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pb_out <= '0;
      pb_oe  <= '0;
    end else if (stop_mode) begin
      pb_oe <= '0;
    end else begin
      case (mode)
        host_port_pkg::MODE_GPIO: begin
          pb_oe  <= gpio_dir;
          pb_out <= gpio_out;
        end
        host_port_pkg::MODE_NONMUX,
        host_port_pkg::MODE_MUX: begin
          pb_oe <= '0;
          if (rd_act && sel) begin
            pb_oe[7:0]  <= 8'hFF;
            pb_out[7:0] <= read_byte(addr_reg[2:0]);
          end
        end
        default: pb_oe <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gpio_in_val <= '0;
    end else if (!stop_mode) begin
      gpio_in_val <= pins_s;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_word_transfer: assert property (
    wr_go && addr_reg[2:0] == host_port_pkg::ADDR_LOW
      |=> core_rx_valid && !transmit_empty_flag
          && core_side_receive_word[7:0] == $past(pins_s[7:0]))
    else $error("host low byte write did not reach core word");
  chk_ctrl_follow: assert property (
    1'b1 |=> ctrl_reg == $past(port_ctrl))
    else $error("port control register did not follow its input");
  chk_nonmux_idle: assert property (
    mode == host_port_pkg::MODE_NONMUX && !stop_mode && !(rd_act && cs_act)
      |=> pb_oe == '0)
    else $error("data pins driven without selected read");
  chk_mux_read: assert property (
    mode == host_port_pkg::MODE_MUX && !stop_mode && rd_act
      |=> pb_oe[7:0] == 8'hFF && pb_oe[15:8] == 8'h00)
    else $error("multiplexed read did not drive shared pins");
  chk_gpio_dir: assert property (
    mode == host_port_pkg::MODE_GPIO && !stop_mode
      |=> pb_oe == $past(gpio_dir) && pb_out == $past(gpio_out))
    else $error("gpio direction or level not applied");
  chk_nonmux_addr: assert property (
    mode == host_port_pkg::MODE_NONMUX && !stop_mode
      |=> addr_reg == {8'h00, $past(pins_s[10:8])})
    else $error("non-multiplexed address not taken from address pins");
  chk_mux_strobe: assert property (
    mode == host_port_pkg::MODE_MUX && !stop_mode && as_act
      |=> addr_reg == {$past(pins_s[13]), $past(pins_s[10:9]), $past(pins_s[7:0])})
    else $error("multiplexed address not latched under strobe");
  chk_cs_gate: assert property (
    mode == host_port_pkg::MODE_NONMUX && !cs_act && wr_end
      |=> $stable(transmit_empty_flag) || $past(core_rx_ack))
    else $error("write taken without chip select");
  chk_stop_hold: assert property (
    stop_mode |=> pb_oe == '0 && $stable(gpio_in_val) && $stable(pb_out))
    else $error("pins not held in stop");
  chk_sync_delay: assert property (
    !stop_mode && !$past(reset) && !$past(reset, 2) |=> gpio_in_val == $past(pb_in, 3))
    else $error("pin input not seen through two synchroniser stages");
  chk_reset_quiet: assert property (
    @(posedge clk_sys) disable iff (1'b0)
      reset |=> pb_oe == '0 && !core_rx_valid && gpio_in_val == '0)
    else $error("outputs active or inputs taken during reset");

  cov_host_write: cover property (wr_go && addr_reg[2:0] == host_port_pkg::ADDR_LOW);
  cov_host_read:  cover property (rd_go && addr_reg[2:0] == host_port_pkg::ADDR_LOW);
  cov_command:    cover property (wr_go && addr_reg[2:0] == host_port_pkg::ADDR_CMD);
  cov_gpio:       cover property (mode == host_port_pkg::MODE_GPIO && gpio_dir != '0);
endmodule : host_port_pin_config
`default_nettype wire

// ### test/host_bus_model.sv
// Host processor model driving the host port pins
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] port_ctrl,
  input  wire logic [15:0] pins,
  input  wire logic        host_command_bit,
  output logic      [15:0] host_lvl
);
  initial host_lvl = 16'h3800;

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : hold

  // Address phase; sel low leaves chip select inactive
  task automatic addr_phase(input logic [2:0] addr, input logic sel);
    if (port_ctrl[1]) begin
      host_lvl[8] = ~port_ctrl[2];
      host_lvl[7:0] = {5'h00, addr};
      // Nonzero high address bits so their capture is visible
      {host_lvl[13], host_lvl[10], host_lvl[9]} = 3'h5;
      hold(1);
      host_lvl[8] = port_ctrl[2];
      hold(4);
      host_lvl[8] = ~port_ctrl[2];
      hold(2);
    end else begin
      host_lvl[10:8] = addr;
      host_lvl[13] = sel ? port_ctrl[3] : ~port_ctrl[3];
      hold(1);
    end
  endtask : addr_phase

  // Released lines show the inverse of the last value
  task automatic end_phase();
    host_lvl[7:0] = ~host_lvl[7:0];
    if (!port_ctrl[1]) host_lvl[13] = ~port_ctrl[3];
    hold(1);
  endtask : end_phase

  task automatic bus_write(input logic [2:0] addr, input logic [7:0] data, input logic sel);
    addr_phase(addr, sel);
    host_lvl[7:0] = data;
    host_lvl[12] = 1'b0;
    hold(4);
    host_lvl[12] = 1'b1;
    hold(4);
    end_phase();
  endtask : bus_write

  task automatic bus_read(input logic [2:0] addr, output logic [7:0] data);
    addr_phase(addr, 1'b1);
    host_lvl[7:0] = ~host_lvl[7:0];
    host_lvl[11] = 1'b0;
    hold(5);
    data = pins[7:0];
    host_lvl[11] = 1'b1;
    hold(4);
    end_phase();
  endtask : bus_read

  task automatic host_recv(output logic [23:0] w, output logic ok);
    logic [7:0] b;
    ok = 1'b0;
    w = 24'h000000;
    for (int n = 0; n < 20 && !ok; n++) begin
      bus_read(host_port_pkg::ADDR_STATUS, b);
      ok = b[0];
    end
    if (ok) begin
      bus_read(host_port_pkg::ADDR_HIGH, w[23:16]);
      bus_read(host_port_pkg::ADDR_MIDDLE, w[15:8]);
      bus_read(host_port_pkg::ADDR_LOW, w[7:0]);
    end
  endtask : host_recv

  task automatic host_send(input logic [23:0] w, output logic ok);
    logic [7:0] b;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      bus_read(host_port_pkg::ADDR_STATUS, b);
      ok = b[1];
    end
    if (ok) begin
      bus_write(host_port_pkg::ADDR_HIGH, w[23:16], 1'b1);
      bus_write(host_port_pkg::ADDR_MIDDLE, w[15:8], 1'b1);
      bus_write(host_port_pkg::ADDR_LOW, w[7:0], 1'b1);
    end
  endtask : host_send

  task automatic host_cmd(input logic [6:0] vec, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 50 && !ok; n++) begin
      ok = (host_command_bit === 1'b0);
      if (!ok) hold(1);
    end
    if (ok) bus_write(host_port_pkg::ADDR_CMD, {1'b1, vec}, 1'b1);
  endtask : host_cmd
endmodule : host_bus_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the host port pin logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys, reset, stop_mode, ok;
  logic [15:0] port_ctrl, gpio_dir, gpio_out;
  logic [15:0] pb_in, pb_out, pb_oe, gpio_in_val, host_lvl, gv;
  logic [23:0] core_tx_word, core_side_receive_word, w;
  logic        core_tx_load, core_rx_ack, core_cmd_ack;
  logic        core_rx_valid, receive_full_flag, transmit_empty_flag, host_command_bit;
  logic [6:0]  host_vector_value;
  int          num_errors = 0, samples_checked = 0;

  always #5 clk_sys = ~clk_sys;
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & host_lvl);

  host_port_pin_config uut (.port_ctrl(port_ctrl), .clk_sys(clk_sys), .reset(reset),
    .stop_mode(stop_mode), .gpio_dir(gpio_dir), .gpio_out(gpio_out), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .gpio_in_val(gpio_in_val), .core_tx_word(core_tx_word),
    .core_tx_load(core_tx_load), .core_rx_ack(core_rx_ack), .core_cmd_ack(core_cmd_ack),
    .core_side_receive_word(core_side_receive_word), .core_rx_valid(core_rx_valid),
    .receive_full_flag(receive_full_flag), .transmit_empty_flag(transmit_empty_flag),
    .host_vector_value(host_vector_value), .host_command_bit(host_command_bit));

  host_bus_model hm (.clk_sys(clk_sys), .port_ctrl(port_ctrl), .pins(pb_in),
    .host_command_bit(host_command_bit), .host_lvl(host_lvl));

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic pulse(input int which);
    case (which)
      0: core_tx_load = 1'b1;
      1: core_rx_ack = 1'b1;
      default: core_cmd_ack = 1'b1;
    endcase
    hm.hold(1);
    {core_tx_load, core_rx_ack, core_cmd_ack} = 3'h0;
    hm.hold(2);
  endtask : pulse

  // Host word into the core, then core takes it
  task automatic send_word(input logic [23:0] word);
    hm.host_send(word, ok);
    check("send ok", 24'h000001, {23'h0, ok});
    check("core word", word, core_side_receive_word);
    check("rx valid", 24'h000001, {23'h0, core_rx_valid});
    check("empty cleared", 24'h000000, {23'h0, transmit_empty_flag});
    pulse(1);
    check("empty set", 24'h000001, {23'h0, transmit_empty_flag});
  endtask : send_word

  // Core word out to the host
  task automatic recv_word(input logic [23:0] word);
    core_tx_word = word;
    pulse(0);
    check("full set", 24'h000001, {23'h0, receive_full_flag});
    hm.host_recv(w, ok);
    check("recv ok", 24'h000001, {23'h0, ok});
    check("host word", word, w);
    check("full cleared", 24'h000000, {23'h0, receive_full_flag});
  endtask : recv_word

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  initial begin
    {clk_sys, reset, stop_mode, core_tx_load, core_rx_ack, core_cmd_ack} = 6'h10;
    {port_ctrl, gpio_dir, gpio_out, core_tx_word} = 72'h0;
    hm.hold(3);
    reset = 1'b0;
    check("reset oe", 24'h000000, {8'h00, pb_oe});
    check("reset empty", 24'h000001, {23'h0, transmit_empty_flag});
    // General-purpose pins
    gpio_dir = 16'h0F0F;
    gpio_out = 16'h0A05;
    hm.hold(5);
    check("gpio oe", 24'h000F0F, {8'h00, pb_oe});
    check("gpio out", 24'h000A05, {8'h00, pb_out & gpio_dir});
    check("gpio in", {8'h00, 16'h0A05 | (host_lvl & ~16'h0F0F)}, {8'h00, gpio_in_val});
    hm.bus_write(host_port_pkg::ADDR_LOW, 8'h55, 1'b1);
    check("gpio strobe", 24'h000000, {23'h0, core_rx_valid});
    // Stop state
    stop_mode = 1'b1;
    gpio_out = 16'hFFFF;
    hm.hold(2);
    gv = gpio_in_val;
    check("stop oe", 24'h000000, {8'h00, pb_oe});
    check("stop out", 24'h000A05, {8'h00, pb_out & gpio_dir});
    hm.bus_write(host_port_pkg::ADDR_HIGH, 8'hC3, 1'b1);
    check("stop in", {8'h00, gv}, {8'h00, gpio_in_val});
    {stop_mode, gpio_dir, gpio_out} = 33'h0;
    // Non-multiplexed bus, chip select low then high
    port_ctrl = 16'h0001;
    hm.hold(3);
    send_word(24'h123456);
    hm.bus_write(host_port_pkg::ADDR_LOW, 8'h99, 1'b0);
    check("no select", 24'h000000, {23'h0, core_rx_valid});
    port_ctrl = 16'h0009;
    hm.hold(3);
    hm.bus_write(host_port_pkg::ADDR_LOW, 8'h77, 1'b1);
    check("select high", 24'h000077, {16'h0000, core_side_receive_word[7:0]});
    pulse(1);
    recv_word(24'hABCDEF);
    hm.host_cmd(7'h2A, ok);
    check("cmd bit", 24'h000001, {23'h0, host_command_bit});
    check("vector", 24'h00002A, {17'h0, host_vector_value});
    pulse(2);
    check("cmd clear", 24'h000000, {23'h0, host_command_bit});
    // Multiplexed bus, both strobe polarities
    port_ctrl = 16'h0003;
    hm.hold(3);
    send_word(24'h0F1E2D);
    port_ctrl = 16'h0007;
    hm.hold(3);
    send_word(24'h3C4B5A);
    recv_word(24'h13579B);
    // Strobes during reset
    port_ctrl = 16'h0001;
    reset = 1'b1;
    hm.bus_write(host_port_pkg::ADDR_LOW, 8'hAA, 1'b1);
    reset = 1'b0;
    hm.hold(4);
    check("reset strobe", 24'h000000, {23'h0, core_rx_valid});
    check("reset empty2", 24'h000001, {23'h0, transmit_empty_flag});
    check("reset word", 24'h000000, core_side_receive_word);
    conclude();
  end
endmodule : tb
`default_nettype wire
